/* File: design/rpls_pkg.sv */
// Constants, types and carriers of the reset and low-power sequencer
package rpls_pkg;

	// ****************************************
	// Timing figures, in the cycles they are given in
	// ****************************************
	localparam int REF_PER_CLK = 1;
	localparam int LOCK_REF_CYC = 4096;
	localparam int START_HALF_CYC = 36;
	localparam int START_OUT_CYC = START_HALF_CYC / 2;
	localparam int WDOG_REF_CYC = 128;
	localparam int WAKE0_OUT_CYC = 12;
	localparam int WAKE1_OUT_CYC = 15;
	localparam int STOP_OUT_CYC = 4;
	localparam int INT_OUT_CYC = 10;
	localparam int FAULT_SHORT_OUT = 6;
	localparam int FAULT_LONG_OUT = 12;
	localparam int OSC_START_REF_CYC = 1024;
	localparam int LOCK_CLK = LOCK_REF_CYC * REF_PER_CLK;
	localparam int WDOG_CLK = WDOG_REF_CYC * REF_PER_CLK;

	// ****************************************
	// Core clock divider, last count of each half period and log2 of its period; synchroniser reset value
	// ****************************************
	localparam logic [1:0] DIV_FAST_HALF = 2'h1;
	localparam logic [1:0] DIV_SLOW_HALF = 2'h3;
	localparam logic [2:0] OUT_SHIFT_FAST = 3'h2;
	localparam logic [2:0] OUT_SHIFT_SLOW = 3'h3;
	localparam logic [3:0] SYNC_RESET_VAL = 4'h7; // Reset pin reads low, others idle high

	// ****************************************
	// Enumerations and carriers
	// ****************************************
	typedef enum logic [2:0] {
		S_HOLD = 3'h0,
		S_LOCK = 3'h1,
		S_START = 3'h3,
		S_RUN = 3'h2,
		S_ENTER = 3'h6,
		S_SLEEP = 3'h7,
		S_RESUME = 3'h5,
		S_WDOG = 3'h4
	} rpls_state_e;

	typedef enum logic [1:0] {
		LPM_ZERO = 2'h0,
		LPM_ONE = 2'h1,
		LPM_TWO = 2'h2,
		LPM_NONE = 2'h3
	} rpls_lpm_e;

	typedef enum logic [1:0] {
		IDLE_NONE = 2'h0,
		IDLE_ONE = 2'h1,
		IDLE_TWO = 2'h2,
		IDLE_HALT = 2'h3
	} rpls_idle_e;

	typedef enum logic [1:0] {
		VEC_NONE = 2'h0,
		VEC_RESET = 2'h1,
		VEC_INT = 2'h2,
		VEC_FAULT = 2'h3
	} rpls_vec_e;

	typedef struct packed {
		logic reset_n;
		logic fault_n;
		logic [1:0] ext_int_n;
	} rpls_pins_s;

	typedef struct packed {
		logic cpu_run;
		logic periph_clk_en;
		logic flash_on;
		logic osc_en;
		rpls_lpm_e lpm;
	} rpls_status_s;

endpackage : rpls_pkg

/* File: design/rpls_sync.sv */
// Two-stage synchroniser for a group of pin inputs
module rpls_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] sync
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					meta_q <= RESET_VAL[i];
					sync_q <= RESET_VAL[i];
				end else begin
					meta_q <= pin[i];
					sync_q <= meta_q;
				end
			end
			assign sync[i] = sync_q;
		end
	endgenerate
endmodule : rpls_sync

/* File: design/rpls_seq.sv */
// Reset, lock and low-power sequencer top level
module rpls_seq
	import rpls_pkg::*;
#(
	parameter int LOCK_CYC = rpls_pkg::LOCK_CLK,
	parameter int OSC_CYC = rpls_pkg::OSC_START_REF_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic reset_pin_n_in,
	output logic reset_pin_n_out,
	output logic reset_pin_n_oe_n,
	input wire logic [1:0] ext_int_n_in,
	input wire logic power_drive_fault_n,
	input wire logic [1:0] int_enable,
	input wire logic fault_int_enable,
	input wire logic fault_qual_long,
	input wire logic clock_prescale_select,
	input wire logic idle_strobe,
	input wire rpls_pkg::rpls_idle_e idle_kind,
	input wire logic watchdog_reset,
	output logic core_clock_output,
	output rpls_pkg::rpls_status_s status,
	output logic vector_fetch,
	output rpls_pkg::rpls_vec_e vector_kind,
	output logic pwm_high_z
);
	import rpls_pkg::*;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	rpls_pins_s pins_raw;
	rpls_pins_s pins;
	logic [3:0] pins_sync;
	assign pins_raw = '{reset_n: reset_pin_n_in, fault_n: power_drive_fault_n,
		ext_int_n: ext_int_n_in};
	rpls_sync #(.WIDTH(4), .RESET_VAL(SYNC_RESET_VAL)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.pin(pins_raw),
		.sync(pins_sync)
	);
	assign pins = rpls_pins_s'(pins_sync);

	// ****************************************
	// State and registers
	// ****************************************
	rpls_state_e state_q, state_d;
	rpls_lpm_e lpm_q, lpm_d;
	logic [13:0] cnt_q, cnt_d;
	logic halt_wake_q, halt_wake_d;
	logic presc_q;
	logic [1:0] div_q, div_d;
	logic core_clk_q, core_clk_d;
	logic [1:0] int_prev_q;
	logic [7:0] fcnt_q;
	logic int_pend_q, fault_pend_q;
	logic [3:0] vcnt_q;
	rpls_status_s status_q, status_d;
	logic fetch_q;
	rpls_vec_e vkind_q;
	logic drive_n_q;
	logic hz_q;

	// ****************************************
	// Core clock divider, stops in its high phase
	// ****************************************
	logic clk_run;
	logic [1:0] half_top;
	logic div_wrap;
	logic core_rise;
	assign clk_run = (state_q == S_START) || (state_q == S_RUN) || (state_q == S_ENTER)
		|| (state_q == S_RESUME) || (state_q == S_SLEEP && lpm_q == LPM_ZERO);
	assign half_top = presc_q ? DIV_SLOW_HALF : DIV_FAST_HALF;
	assign div_wrap = (div_q == half_top);
	assign core_rise = div_wrap && !core_clk_q && clk_run;
	assign core_clk_d = (!clk_run && core_clk_q) ? 1'b1 : (div_wrap ? !core_clk_q : core_clk_q);
	assign div_d = (div_wrap || (!clk_run && core_clk_q)) ? 2'h0 : div_q + 2'h1;

	// ****************************************
	// Interrupt edges and fault qualification
	// ****************************************
	logic [1:0] int_edge;
	logic int_event;
	logic [7:0] fault_thr;
	logic fault_qual;
	assign int_edge = int_prev_q ^ pins.ext_int_n;
	assign int_event = |(int_edge & int_enable);
	assign fault_thr = presc_q ?
		8'((fault_qual_long ? FAULT_LONG_OUT : FAULT_SHORT_OUT) << OUT_SHIFT_SLOW) :
		8'((fault_qual_long ? FAULT_LONG_OUT : FAULT_SHORT_OUT) << OUT_SHIFT_FAST);
	assign fault_qual = !pins.fault_n && (fcnt_q == fault_thr - 8'h01);

	// ****************************************
	// Sequencing decisions
	// ****************************************
	logic pin_reset;
	logic lock_done;
	logic start_done;
	logic enter_done;
	logic resume_done;
	logic wdog_done;
	logic wake_light;
	logic wake_halt;
	logic [13:0] lock_top;
	assign pin_reset = !pins.reset_n && (state_q != S_WDOG);
	assign lock_top = halt_wake_q ? 14'(LOCK_CYC + OSC_CYC) : 14'(LOCK_CYC);
	assign lock_done = (cnt_q == lock_top - 14'h0001);
	assign start_done = core_rise && (cnt_q == 14'(START_OUT_CYC - 1));
	assign enter_done = core_rise && (cnt_q == 14'(STOP_OUT_CYC));
	assign resume_done = core_rise && (cnt_q == ((lpm_q == LPM_ONE) ?
		14'(WAKE1_OUT_CYC) : 14'(WAKE0_OUT_CYC)));
	assign wdog_done = (cnt_q == 14'(WDOG_CLK - 1));
	assign wake_light = int_event || (fault_qual && fault_int_enable);
	assign wake_halt = int_event || fault_qual;

	always_comb begin
		state_d = state_q;
		lpm_d = lpm_q;
		halt_wake_d = halt_wake_q;
		cnt_d = cnt_q + 14'h0001;
		case (state_q)
			S_HOLD: begin
				cnt_d = 14'h0000;
				halt_wake_d = 1'b0;
				if (pins.reset_n) state_d = S_LOCK;
			end
			S_LOCK: begin
				if (lock_done) begin
					cnt_d = 14'h0000;
					state_d = halt_wake_q ? S_RUN : S_START;
					lpm_d = halt_wake_q ? LPM_NONE : lpm_q;
				end
			end
			S_START: begin
				cnt_d = core_rise ? cnt_q + 14'h0001 : cnt_q;
				if (start_done) state_d = S_RUN;
			end
			S_RUN: begin
				cnt_d = 14'h0000;
				if (watchdog_reset) begin
					state_d = S_WDOG;
				end else if (idle_strobe && idle_kind != IDLE_NONE) begin
					state_d = S_ENTER;
					lpm_d = (idle_kind == IDLE_ONE) ? LPM_ZERO :
						((idle_kind == IDLE_TWO) ? LPM_ONE : LPM_TWO);
				end
			end
			S_ENTER: begin
				cnt_d = core_rise ? cnt_q + 14'h0001 : cnt_q;
				if (enter_done) begin
					cnt_d = 14'h0000;
					state_d = S_SLEEP;
				end
			end
			S_SLEEP: begin
				cnt_d = 14'h0000;
				if (lpm_q == LPM_TWO && wake_halt) begin
					state_d = S_LOCK;
					halt_wake_d = 1'b1;
				end else if (lpm_q != LPM_TWO && wake_light) begin
					state_d = S_RESUME;
				end
			end
			S_RESUME: begin
				cnt_d = core_rise ? cnt_q + 14'h0001 : cnt_q;
				if (resume_done) begin
					state_d = S_RUN;
					lpm_d = LPM_NONE;
				end
			end
			S_WDOG: begin
				if (wdog_done) state_d = S_HOLD;
			end
			default: begin
				state_d = S_HOLD;
			end
		endcase
		if (pin_reset) begin
			state_d = S_HOLD;
			lpm_d = LPM_NONE;
		end
	end

	// ****************************************
	// Status outputs for the next state
	// ****************************************
	always_comb begin
		status_d.cpu_run = (state_d == S_RUN);
		status_d.lpm = lpm_d;
		status_d.periph_clk_en = !(state_d == S_SLEEP && lpm_d != LPM_ZERO);
		status_d.flash_on = !(state_d == S_SLEEP && lpm_d == LPM_TWO);
		status_d.osc_en = !(state_d == S_SLEEP && lpm_d == LPM_TWO);
	end

	// ****************************************
	// Vector selection
	// ****************************************
	logic vec_ready;
	logic take_fault;
	logic take_int;
	assign vec_ready = status_q.cpu_run && (vcnt_q > 4'(INT_OUT_CYC));
	assign take_fault = vec_ready && fault_pend_q && !start_done;
	assign take_int = vec_ready && int_pend_q && !fault_pend_q && !start_done;

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_HOLD;
			lpm_q <= LPM_NONE;
			cnt_q <= 14'h0000;
			halt_wake_q <= 1'b0;
			status_q <= '{cpu_run: 1'b0, periph_clk_en: 1'b1, flash_on: 1'b1,
				osc_en: 1'b1, lpm: LPM_NONE};
		end else begin
			state_q <= state_d;
			lpm_q <= lpm_d;
			cnt_q <= cnt_d;
			halt_wake_q <= halt_wake_d;
			status_q <= status_d;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			presc_q <= 1'b0;
			div_q <= 2'h0;
			core_clk_q <= 1'b1;
		end else begin
			if (state_q == S_RUN || state_q == S_HOLD) presc_q <= clock_prescale_select;
			div_q <= div_d;
			core_clk_q <= core_clk_d;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			int_prev_q <= 2'h3;
			fcnt_q <= 8'h00;
		end else begin
			int_prev_q <= pins.ext_int_n;
			fcnt_q <= pins.fault_n ? 8'h00 : ((fcnt_q >= fault_thr) ? fcnt_q : fcnt_q + 8'h01);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			int_pend_q <= 1'b0;
			fault_pend_q <= 1'b0;
			vcnt_q <= 4'h0;
			fetch_q <= 1'b0;
			vkind_q <= VEC_NONE;
		end else begin
			int_pend_q <= (int_pend_q && !take_int) || int_event;
			fault_pend_q <= (fault_pend_q && !take_fault) || (fault_qual && fault_int_enable);
			if (int_event || (fault_qual && fault_int_enable)) vcnt_q <= 4'h0;
			else if (core_rise && vcnt_q != 4'hF) vcnt_q <= vcnt_q + 4'h1;
			fetch_q <= start_done || take_fault || take_int;
			vkind_q <= start_done ? VEC_RESET : (take_fault ? VEC_FAULT :
				(take_int ? VEC_INT : VEC_NONE));
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) drive_n_q <= 1'b1;
		else drive_n_q <= (state_d != S_WDOG);
	end

	// Asynchronous fault path, no clock needed to float the PWM pins
	always_ff @(posedge clock or negedge nrst or negedge power_drive_fault_n) begin
		if (!nrst) hz_q <= 1'b0;
		else if (!power_drive_fault_n) hz_q <= 1'b1;
		else if (pins.fault_n) hz_q <= 1'b0;
	end

	assign reset_pin_n_out = drive_n_q;
	assign reset_pin_n_oe_n = drive_n_q;
	assign core_clock_output = core_clk_q;
	assign status = status_q;
	assign vector_fetch = fetch_q;
	assign vector_kind = vkind_q;
	assign pwm_high_z = hz_q;

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] drv_len_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) drv_len_q <= 8'h00;
		else if (reset_pin_n_oe_n) drv_len_q <= 8'h00;
		else if (drv_len_q != 8'hFF) drv_len_q <= drv_len_q + 8'h01;
	end

	wdog_drive_len_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(reset_pin_n_oe_n) |-> drv_len_q >= 8'(WDOG_CLK))
		else $error("reset pin released before watchdog time");
	lock_gate_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == S_LOCK) |-> !status.cpu_run)
		else $error("cpu ran during lock");
	reset_vector_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == S_START && start_done) |=> vector_fetch && vector_kind == VEC_RESET
		##1 status.cpu_run)
		else $error("reset vector not fetched after start");
	clock_stop_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == S_SLEEP && lpm_q != LPM_ZERO) |-> core_clock_output)
		else $error("core clock not stopped high");
	osc_off_a: assert property (@(posedge clock) disable iff (!nrst)
		$fell(status.osc_en) |-> $past(state_q) == S_ENTER && $past(lpm_q) == LPM_TWO)
		else $error("oscillator off outside halt entry");
	idle_map_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == S_RUN && !pin_reset && !watchdog_reset && idle_strobe
		&& idle_kind == IDLE_TWO) |=> lpm_q == LPM_ONE && state_q == S_ENTER)
		else $error("idle level two not mapped to mode one");
	fault_hz_a: assert property (@(posedge clock) disable iff (!nrst)
		!power_drive_fault_n |-> pwm_high_z)
		else $error("pwm not floated on fault");
	int_delay_a: assert property (@(posedge clock) disable iff (!nrst)
		(vector_fetch && vector_kind == VEC_INT) |-> $past(vcnt_q) > 4'(INT_OUT_CYC))
		else $error("interrupt vector fetched too early");
	gating_a: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == S_SLEEP && lpm_q == LPM_TWO) |=> state_q != S_SLEEP
		|| (!status.flash_on && !status.periph_clk_en && !status.osc_en))
		else $error("halt gating incomplete");
endmodule : rpls_seq

/* File: verification/rpls_partner.sv */
// Far-side model: reset supervisor, interrupt sources and fault pin
module rpls_partner (
	input wire logic clock,
	input wire logic hold_req,
	input wire logic [1:0] int_tgl,
	input wire logic fault_low,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic reset_pin_n_in,
	output logic [1:0] ext_int_n_in,
	output logic power_drive_fault_n
);
	timeunit 1ns;
	timeprecision 100ps;
	int hold_cnt = 0;
	logic [1:0] int_lvl = 2'h3;

	// ****************************************
	// Supervisor, pulled-up reset wire, sources
	// ****************************************
	always @(posedge clock) begin
		if (hold_req) begin
			hold_cnt <= 0;
		end else if (hold_cnt < 8) begin
			hold_cnt <= hold_cnt + 1;
		end
		int_lvl <= int_lvl ^ int_tgl;
	end
	assign reset_pin_n_in = !(hold_req || hold_cnt < 8 || (!pin_oe_n && !pin_out));
	assign ext_int_n_in = int_lvl;
	assign power_drive_fault_n = !fault_low;
endmodule : rpls_partner

/* File: verification/test_rpls_seq.sv */
// Self-checking bench of the reset and low-power sequencer
module test_rpls_seq;
	timeunit 1ns;
	timeprecision 100ps;
	import rpls_pkg::*;

	// ****************************************
	// Stimulus, wiring and scoreboard
	// ****************************************
	localparam int LOCK = 16;
	localparam int OSC = 8;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic hold_req = 1'b1;
	logic fault_low = 1'b0;
	logic fault_int_enable = 1'b0;
	logic fault_qual_long = 1'b0;
	logic clock_prescale_select = 1'b0;
	logic idle_strobe = 1'b0;
	logic watchdog_reset = 1'b0;
	logic [1:0] int_enable = 2'h3;
	logic [1:0] int_tgl = 2'h0;
	rpls_idle_e idle_kind = IDLE_NONE;
	logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe_n, core_clock_output;
	logic vector_fetch, pwm_high_z, power_drive_fault_n;
	logic [1:0] ext_int_n_in;
	rpls_status_s status;
	rpls_vec_e vector_kind;
	rpls_vec_e exp_q[$];
	int fails = 0;
	int check_count = 0;
	int per = 4;
	int t;
	int b;
	int len;

	always #5 clock = ~clock;

	rpls_seq #(.LOCK_CYC(LOCK), .OSC_CYC(OSC)) rpls_seq_i (
		.clock(clock), .nrst(nrst), .reset_pin_n_in(reset_pin_n_in),
		.reset_pin_n_out(reset_pin_n_out), .reset_pin_n_oe_n(reset_pin_n_oe_n),
		.ext_int_n_in(ext_int_n_in), .power_drive_fault_n(power_drive_fault_n),
		.int_enable(int_enable), .fault_int_enable(fault_int_enable),
		.fault_qual_long(fault_qual_long), .clock_prescale_select(clock_prescale_select),
		.idle_strobe(idle_strobe), .idle_kind(idle_kind), .watchdog_reset(watchdog_reset),
		.core_clock_output(core_clock_output), .status(status),
		.vector_fetch(vector_fetch), .vector_kind(vector_kind), .pwm_high_z(pwm_high_z)
	);

	rpls_partner rpls_partner_i (
		.clock(clock), .hold_req(hold_req), .int_tgl(int_tgl), .fault_low(fault_low),
		.pin_out(reset_pin_n_out), .pin_oe_n(reset_pin_n_oe_n),
		.reset_pin_n_in(reset_pin_n_in), .ext_int_n_in(ext_int_n_in),
		.power_drive_fault_n(power_drive_fault_n)
	);

	// ****************************************
	// Compare, wait and report tasks
	// ****************************************
	task cmp_val(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : cmp_val

	task cmp_span(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			fails++;
			$display("Error at %0t: got %0h cycles expected %0h to %0h", $time, got, lo, hi);
		end
	endtask : cmp_span

	task final_report;
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : clk

	task wait_run(output int n);
		n = 0;
		do begin
			clk(1);
			n++;
		end while (status.cpu_run !== 1'b1 && n < 5000);
	endtask : wait_run

	task count_rises(output int r);
		logic prev;
		r = 0;
		prev = core_clock_output;
		repeat (64) begin
			clk(1);
			if (core_clock_output === 1'b1 && prev === 1'b0) r++;
			prev = core_clock_output;
		end
	endtask : count_rises

	task tgl_int;
		b = $urandom % 2;
		@(posedge clock);
		int_tgl[b] <= 1'b1;
		@(posedge clock);
		int_tgl <= 2'h0;
	endtask : tgl_int

	task go_idle(input rpls_idle_e k, input rpls_lpm_e m);
		int n;
		int r;
		@(posedge clock);
		idle_kind <= k;
		idle_strobe <= 1'b1;
		@(posedge clock);
		idle_strobe <= 1'b0;
		n = 0;
		do begin
			clk(1);
			n++;
		end while (status.osc_en !== 1'b0 && n < 12 * per);
		if (k == IDLE_HALT) cmp_span(n, 4 * per, 6 * per + 8);
		clk(8 * per);
		cmp_val({status.cpu_run, status.lpm}, {1'b0, m});
		count_rises(r);
		if (m == LPM_ZERO) cmp_val(status.periph_clk_en, 1'b1);
		else cmp_val({r[3:0], core_clock_output}, 5'h01);
		if (m == LPM_TWO) cmp_val({status.periph_clk_en, status.flash_on, status.osc_en}, 3'h0);
	endtask : go_idle

	// Every vector fetched is checked against the expected queue
	always @(posedge clock) begin
		if (nrst === 1'b1 && vector_fetch === 1'b1) begin
			if (exp_q.size() == 0) cmp_val(vector_kind, VEC_NONE);
			else cmp_val(vector_kind, exp_q.pop_front());
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		void'($urandom(32'h02f077b9));
		b = $urandom % 2;
		per = b ? 8 : 4;
		clock_prescale_select <= 1'(b);
		fault_qual_long <= 1'($urandom % 2);
		fault_int_enable <= 1'($urandom % 2);
		clk(16);
		@(posedge clock);
		nrst <= 1'b1;
		clk(1);
		cmp_val({reset_pin_n_oe_n, reset_pin_n_out, status}, 8'hDF);
		exp_q.push_back(VEC_RESET);
		@(posedge clock);
		hold_req <= 1'b0;
		wait_run(t);
		cmp_span(t, 8 + LOCK + 18 * per, 8 + LOCK + 19 * per + 12);
		$display("test reset_start done");
		exp_q.push_back(VEC_INT);
		tgl_int;
		t = 1;
		while (vector_fetch !== 1'b1 && t < 200) begin
			clk(1);
			t++;
		end
		cmp_span(t, 10 * per, 11 * per + 12);
		$display("test int_vector done");
		for (int i = 0; i < 2; i++) begin
			go_idle(i ? IDLE_TWO : IDLE_ONE, i ? LPM_ONE : LPM_ZERO);
			@(posedge clock);
			int_enable <= 2'h0;
			tgl_int;
			clk(100);
			cmp_val(status.cpu_run, 1'b0);
			@(posedge clock);
			int_enable <= 2'h3;
			exp_q.push_back(VEC_INT);
			tgl_int;
			wait_run(t);
			cmp_span(t + 1, (i ? 15 : 12) * per, (i ? 16 : 13) * per + 12);
			clk(40 * per);
			$display("test low_power_mode %0d done", i);
		end
		go_idle(IDLE_HALT, LPM_TWO);
		len = fault_qual_long ? 12 : 6;
		@(posedge clock);
		clock_prescale_select <= ~clock_prescale_select;
		fault_low <= 1'b1;
		#1;
		cmp_val(pwm_high_z, 1'b1);
		clk((len - 1) * per - 2);
		@(posedge clock);
		fault_low <= 1'b0;
		clock_prescale_select <= ~clock_prescale_select;
		clk(OSC + LOCK + 20 * per);
		cmp_val(status.cpu_run, 1'b0);
		if (fault_int_enable) exp_q.push_back(VEC_FAULT);
		@(posedge clock);
		fault_low <= 1'b1;
		clk((len + 1) * per);
		@(posedge clock);
		fault_low <= 1'b0;
		wait_run(t);
		t = t + (len + 1) * per + 1;
		cmp_span(t, len * per + OSC + LOCK, len * per + OSC + LOCK + 2 * per + 20);
		count_rises(t);
		cmp_span(t, 64 / per - 1, 64 / per);
		clk(40 * per);
		$display("test halt_wake done");
		exp_q.push_back(VEC_RESET);
		@(posedge clock);
		watchdog_reset <= 1'b1;
		@(posedge clock);
		watchdog_reset <= 1'b0;
		clk(2);
		cmp_val({reset_pin_n_oe_n, reset_pin_n_out, reset_pin_n_in}, 3'h0);
		t = 0;
		while (reset_pin_n_oe_n === 1'b0 && t < 300) begin
			clk(1);
			t++;
		end
		cmp_span(t + 2, WDOG_CLK, WDOG_CLK + 2);
		wait_run(t);
		cmp_span(t, LOCK + 18 * per, LOCK + 19 * per + 12);
		$display("test watchdog done");
		clk(100);
		cmp_val(8'(exp_q.size()), 8'h00);
		final_report;
	end

	initial begin
		#200000;
		fails++;
		$display("Error at %0t: run did not finish", $time);
		final_report;
	end
endmodule : test_rpls_seq
